// ===== verilog/dcb_pkg.sv
/*
 Constants for the control word decode: field positions, reset values, timing counts.
 Assumes a 16-bit control word delivered already assembled by a serial front end.
*/
package dcb_pkg;
   // ==========================================
   // Word layout
   localparam int WORD_W       = 16;
   localparam int ADDR_HI_POS  = 15;
   localparam int ADDR_LO_POS  = 14;
   localparam int PSEL_POS     = 10;
   localparam int SRC_POS      = 9;
   localparam int SWRST_POS    = 8;
   localparam int CLKGATE_POS  = 7;
   localparam int DACPD_POS    = 6;
   localparam int OUTEN_POS    = 5;
   localparam int CMPRT_POS    = 4;
   localparam int HALVE_POS    = 3;
   localparam int MODE_POS     = 1;
   // ==========================================
   // Reset values
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   // ==========================================
   // Timing
   localparam int OUT_DELAY_CYC = 7;
   localparam logic [2:0] OUT_DELAY_CNT = 3'h7;
endpackage

// ===== verilog/dcb_sync.sv
/*
 Three flip-flop synchroniser for one pin; output changes when stages two and three agree.
 Assumes the pin is asynchronous to clk_i.
*/
`timescale 1ns/1ps
module dcb_sync (
   input  wire logic clk_i,
   input  wire logic reset_i,
   input  wire logic pin_i,
   output logic      level_o
);
   logic [2:0] sh_reg;
   logic [2:0] sh_next;
   logic       lvl_reg;
   logic       lvl_next;

   always_comb begin
      sh_next  = {sh_reg[1:0], pin_i};
      lvl_next = (sh_reg[1] == sh_reg[2]) ? sh_reg[2] : lvl_reg;
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         sh_reg  <= 3'h0;
         lvl_reg <= 1'b0;
      end else begin
         sh_reg  <= sh_next;
         lvl_reg <= lvl_next;
      end
   end

   assign level_o = lvl_reg;
endmodule

// ===== verilog/dcb_decode.sv
/*
 Control word decode of a DDS: selects, resets, clock gate, DAC power-down, sign output routing.
 Assumes word_valid_i pulses one cycle with an assembled 16-bit word; pins are asynchronous.
*/
`timescale 1ns/1ps
// How it works
// - Under software control bit 10 picks phase offset register zero or one.
// - Bit 9 picks pins or register bits as source for selects, reset and DAC power-down.
// - Source bit one takes the pins, zero takes the register bits.
// - Bit 8 set holds the synthesis registers cleared at midscale; clear releases it.
// - Bit 7 set gates the internal master clock so output holds.
// - Bit 6 set powers down the DAC.
// - Bit 5 enables the sign output driver, else the pin floats.
// - Bit 4 set routes the comparator to the sign pin.
// - Bit 4 clear routes the DAC data MSB or its halved form to the sign pin.
// - Bit 3 set passes the MSB directly, clear passes it divided by two.
// - Bit 1 set bypasses the sine table for a triangle, clear selects sine.
// - A word is a control write only when bits 15 and 14 are both zero.
// - Bits 8, 7 and 6 take effect on the falling master clock edge; bits 10, 5, 4 and 3 on the next rising edge.
// - The DAC output becomes valid seven master clock cycles after reset release.
module dcb_decode (
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic        word_valid_i,
   input  wire logic [15:0] word_i,
   input  wire logic        fsel_pin_i,
   input  wire logic        psel_pin_i,
   input  wire logic        reset_pin_i,
   input  wire logic        sleep_pin_i,
   input  wire logic        fsel_bit_i,
   input  wire logic        comparator_i,
   input  wire logic        dac_msb_i,
   output logic             freq_sel_o,
   output logic             phase_sel_o,
   output logic             synth_clear_o,
   output logic             clock_gate_o,
   output logic             dac_powerdown_o,
   output logic             triangle_mode_o,
   output logic             dac_out_valid_o,
   output logic             sign_out_o,
   output logic             sign_out_oe_o
);
   // ==========================================
   // Pin synchronisers (DAC MSB passes through unsynchronised)
   logic fsel_s;
   logic psel_s;
   logic rst_s;
   logic slp_s;

   dcb_sync u_fs (.clk_i(clk_i), .reset_i(reset_i), .pin_i(fsel_pin_i),   .level_o(fsel_s));
   dcb_sync u_ps (.clk_i(clk_i), .reset_i(reset_i), .pin_i(psel_pin_i),   .level_o(psel_s));
   dcb_sync u_rs (.clk_i(clk_i), .reset_i(reset_i), .pin_i(reset_pin_i),  .level_o(rst_s));
   dcb_sync u_sl (.clk_i(clk_i), .reset_i(reset_i), .pin_i(sleep_pin_i),  .level_o(slp_s));
   logic cmp_s;
   logic msb_s;
   dcb_sync u_cp (.clk_i(clk_i), .reset_i(reset_i), .pin_i(comparator_i), .level_o(cmp_s));
   assign msb_s = dac_msb_i;

   // ==========================================
   // Control word capture (mode bit immediate)
   logic [15:0] ctrl_reg;
   logic [15:0] ctrl_next;
   logic        mode_reg;
   logic        mode_next;

   always_comb begin
      ctrl_next = ctrl_reg;
      mode_next = mode_reg;
      if (word_valid_i && !word_i[dcb_pkg::ADDR_HI_POS] && !word_i[dcb_pkg::ADDR_LO_POS]) begin
         ctrl_next = word_i;
         mode_next = word_i[dcb_pkg::MODE_POS];
      end
   end

   // ==========================================
   // Falling-edge sampled fields
   logic [15:0] fld_reg;
   always_ff @(negedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         fld_reg <= dcb_pkg::CTRL_RESET;
      end else begin
         fld_reg <= ctrl_reg;
      end
   end

   logic src_pin;
   logic sw_reset;
   logic sw_pd;
   assign src_pin  = fld_reg[dcb_pkg::SRC_POS];
   assign sw_reset = src_pin ? rst_s : fld_reg[dcb_pkg::SWRST_POS];
   assign sw_pd    = src_pin ? slp_s : fld_reg[dcb_pkg::DACPD_POS];

   // ==========================================
   // Outputs, MSB halving and release counter
   logic       half_reg;
   logic       half_next;
   logic       prev_msb_reg;
   logic       prev_msb_next;
   logic [2:0] dly_reg;
   logic [2:0] dly_next;
   logic       valid_reg;
   logic       valid_next;
   logic       fsel_reg;
   logic       fsel_next;
   logic       psel_reg;
   logic       psel_next;
   logic       sign_reg;
   logic       sign_next;
   logic       oe_reg;
   logic       oe_next;

   always_comb begin
      prev_msb_next = msb_s;
      half_next     = half_reg;
      if (msb_s && !prev_msb_reg) begin
         half_next = !half_reg;
      end
      fsel_next = src_pin ? fsel_s : fsel_bit_i;
      psel_next = src_pin ? psel_s : fld_reg[dcb_pkg::PSEL_POS];
      dly_next  = dly_reg;
      valid_next = valid_reg;
      if (sw_reset) begin
         dly_next   = 3'h0;
         valid_next = 1'b0;
         half_next  = 1'b0;
      end else if (!valid_reg && !fld_reg[dcb_pkg::CLKGATE_POS]) begin
         if (dly_reg == dcb_pkg::OUT_DELAY_CNT - 3'h1) begin
            valid_next = 1'b1;
         end
         dly_next = dly_reg + 3'h1;
      end
      if (fld_reg[dcb_pkg::CMPRT_POS]) begin
         sign_next = cmp_s;
      end else if (fld_reg[dcb_pkg::HALVE_POS]) begin
         sign_next = msb_s;
      end else begin
         sign_next = half_reg;
      end
      oe_next = fld_reg[dcb_pkg::OUTEN_POS];
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ctrl_reg     <= dcb_pkg::CTRL_RESET;
         mode_reg     <= 1'b0;
         half_reg     <= 1'b0;
         prev_msb_reg <= 1'b0;
         dly_reg      <= 3'h0;
         valid_reg    <= 1'b0;
         fsel_reg     <= 1'b0;
         psel_reg     <= 1'b0;
         sign_reg     <= 1'b0;
         oe_reg       <= 1'b0;
      end else begin
         ctrl_reg     <= ctrl_next;
         mode_reg     <= mode_next;
         half_reg     <= half_next;
         prev_msb_reg <= prev_msb_next;
         dly_reg      <= dly_next;
         valid_reg    <= valid_next;
         fsel_reg     <= fsel_next;
         psel_reg     <= psel_next;
         sign_reg     <= sign_next;
         oe_reg       <= oe_next;
      end
   end

   assign freq_sel_o      = fsel_reg;
   assign phase_sel_o     = psel_reg;
   assign synth_clear_o   = sw_reset;
   assign clock_gate_o    = fld_reg[dcb_pkg::CLKGATE_POS];
   assign dac_powerdown_o = sw_pd;
   assign triangle_mode_o = mode_reg;
   assign dac_out_valid_o = valid_reg;
   assign sign_out_o      = sign_reg;
   assign sign_out_oe_o   = oe_reg;

   // ==========================================
   // Checks
   sequence ctrl_wr_s;
      word_valid_i && word_i[15:14] == 2'b00;
   endsequence

   ctrl_load_a: assert property (@(posedge clk_i) disable iff (reset_i)
      ctrl_wr_s |=> ctrl_reg == $past(word_i))
      else $error("control word not loaded");
   addr_block_a: assert property (@(posedge clk_i) disable iff (reset_i)
      word_valid_i && word_i[15:14] != 2'b00 |=> $stable(ctrl_reg))
      else $error("non-control word changed control");
   mode_now_a: assert property (@(posedge clk_i) disable iff (reset_i)
      ctrl_wr_s |=> triangle_mode_o == $past(word_i[1]))
      else $error("mode bit not applied");
   oe_follow_a: assert property (@(posedge clk_i) disable iff (reset_i)
      ##1 oe_reg == $past(fld_reg[5]))
      else $error("sign enable wrong");
   cmp_route_a: assert property (@(posedge clk_i) disable iff (reset_i)
      fld_reg[4] |=> sign_reg == $past(cmp_s))
      else $error("comparator not routed");
   msb_route_a: assert property (@(posedge clk_i) disable iff (reset_i)
      !fld_reg[4] && fld_reg[3] |=> sign_reg == $past(msb_s))
      else $error("msb not routed");
   psel_sw_a: assert property (@(posedge clk_i) disable iff (reset_i)
      !src_pin |=> phase_sel_o == $past(fld_reg[10]))
      else $error("phase select wrong");
   reset_src_a: assert property (@(posedge clk_i) disable iff (reset_i)
      synth_clear_o == (src_pin ? rst_s : fld_reg[8]))
      else $error("reset source wrong");
   pd_src_a: assert property (@(posedge clk_i) disable iff (reset_i)
      dac_powerdown_o == (src_pin ? slp_s : fld_reg[6]))
      else $error("powerdown source wrong");
   release_a: assert property (@(posedge clk_i) disable iff (reset_i)
      $fell(sw_reset) && !clock_gate_o ##0 (!sw_reset && !clock_gate_o) [*7] |=> valid_reg)
      else $error("output not valid after seven cycles");
   gate_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
      clock_gate_o && !sw_reset |=> $stable(dly_reg))
      else $error("counter advanced while gated");
endmodule

// ===== tb/dcb_host.sv
/*
 Host model: sends one control word per call, bits 2 and 0 cleared (bit 1 too when bit 5 is set), as a one-cycle valid pulse.
 Assumes the decode samples word_valid_i on the rising clock edge.
*/
`timescale 1ns/1ps
module dcb_host (
   input  wire logic        clk_i,
   output logic             word_valid_o,
   output logic [15:0]      word_o
);
   // ==========================================
   // Word sender
   initial begin
      word_valid_o = 1'b0;
      word_o       = 16'h0000;
   end
   task automatic send(input logic [15:0] w);
      logic [15:0] v;
      v = w & 16'hFFFA;
      if (v[5]) v[1] = 1'b0;
      @(negedge clk_i);
      word_valid_o = 1'b1;
      word_o       = v;
      @(negedge clk_i);
      word_valid_o = 1'b0;
      word_o       = ~v;
   endtask
endmodule

// ===== tb/tb_dds_control_bits_decode.sv
/*
 Self-checking bench for the control word decode.
 Assumes dcb_host delivers words; pins are driven on the falling edge.
*/
`timescale 1ns/1ps
module tb_dds_control_bits_decode;
   logic        clk_i = 1'b0;
   logic        reset_i, fp, pp, rp, sp, fb, cmp, msb, wv;
   logic        fs, ps, sc, cg, pd, trm, dv, so, oe;
   logic [15:0] wd;
   logic [15:0] tops [3] = '{16'h4000, 16'h8000, 16'hC000};
   int          mismatches = 0;
   int          n_tests = 0;
   int          cyc = 0;
   dcb_host HOST (.clk_i(clk_i), .word_valid_o(wv), .word_o(wd));
   dcb_decode DUT (.clk_i(clk_i), .reset_i(reset_i), .word_valid_i(wv), .word_i(wd),
      .fsel_pin_i(fp), .psel_pin_i(pp), .reset_pin_i(rp), .sleep_pin_i(sp),
      .fsel_bit_i(fb), .comparator_i(cmp), .dac_msb_i(msb), .freq_sel_o(fs),
      .phase_sel_o(ps), .synth_clear_o(sc), .clock_gate_o(cg), .dac_powerdown_o(pd),
      .triangle_mode_o(trm), .dac_out_valid_o(dv), .sign_out_o(so), .sign_out_oe_o(oe));
   // ==========================================
   // Helpers
   task automatic chk(input logic e, input logic g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic wr(input logic [15:0] w);
      HOST.send(w);
      wt(4);
   endtask
   task automatic close_out;
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ==========================================
   // Scenarios
   task automatic t_select;
      fb = 1'b1;
      wr(16'h0400);
      chk(1'b1, ps);
      chk(1'b1, fs);
      wr(16'h0000);
      chk(1'b0, ps);
      pp = 1'b1;
      fb = 1'b0;
      fp = 1'b1;
      wr(16'h0200);
      wt(4);
      chk(1'b1, ps);
      chk(1'b1, fs);
      fp = 1'b0;
      rp = 1'b1;
      sp = 1'b1;
      wt(8);
      chk(1'b0, fs);
      chk(1'b1, sc);
      chk(1'b1, pd);
      {rp, sp, pp} = 3'h0;
      wr(16'h0000);
      wt(12);
   endtask
   task automatic t_clear;
      wr(16'h0100);
      chk(1'b1, sc);
      chk(1'b0, dv);
      wr(16'h0000);
      chk(1'b0, sc);
      chk(1'b0, dv);
      wt(8);
      chk(1'b1, dv);
   endtask
   task automatic t_gates;
      wr(16'h0180);
      wr(16'h0080);
      wt(8);
      chk(1'b0, dv);
      wr(16'h0080);
      chk(1'b1, cg);
      chk(1'b0, pd);
      wr(16'h0042);
      chk(1'b0, cg);
      chk(1'b1, pd);
      chk(1'b1, trm);
      wr(16'h0000);
      chk(1'b0, trm);
      wt(4);
      chk(1'b1, dv);
   endtask
   task automatic t_sign;
      logic s0;
      cmp = 1'b1;
      wr(16'h0030);
      chk(1'b1, oe);
      chk(1'b1, so);
      cmp = 1'b0;
      wt(6);
      chk(1'b0, so);
      wr(16'h0028);
      msb = 1'b1;
      wt(3);
      chk(1'b1, so);
      wr(16'h0020);
      msb = 1'b0;
      wt(3);
      s0 = so;
      msb = 1'b1;
      wt(3);
      chk(~s0, so);
      msb = 1'b0;
      wt(2);
      chk(~s0, so);
      wr(16'h0000);
      chk(1'b0, oe);
   endtask
   task automatic t_refuse;
      foreach (tops[i]) begin
         wr(tops[i] | 16'h0080);
         chk(1'b0, cg);
      end
   endtask
   // ==========================================
   // Clock, timeout and main sequence
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         close_out;
      end
   end
   initial begin
      {reset_i, fp, pp, rp, sp, fb, cmp, msb} = 8'h80;
      wt(2);
      reset_i = 1'b0;
      chk(1'b0, sc);
      wt(9);
      chk(1'b1, dv);
      t_select;
      t_clear;
      t_gates;
      t_sign;
      t_refuse;
      close_out;
   end
endmodule
